// ==== verilog/eeprom_target.sv ====
`default_nettype none
module eeprom_target #(
	parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
	parameter int unsigned MEM_AW      = eeprom_pkg::MEM_AW,
	parameter int unsigned PAGE_AW     = eeprom_pkg::PAGE_AW
) (
	// Clock and power-on reset
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	// Straps and protection
	input  wire logic [2:0] chip_select_straps_i,
	input  wire logic       write_protect_input_i,
	// Status
	output logic            busy_o,
	// Two-wire bus
	twi_if.target           bus
);
	// ****************************************
	// Input synchronisers and bus conditions
	// ****************************************
	logic [5:0] sync_q;
	logic       scl_q;
	logic       sda_q;
	logic [2:0] straps_q;
	logic       wp_q;
	logic       scl_d_ff;
	logic       sda_d_ff;

	line_sync #(.W(6)) u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.d_i     ({bus.scl, bus.sda, chip_select_straps_i, write_protect_input_i}),
		.q_o     (sync_q)
	);
	assign {scl_q, sda_q, straps_q, wp_q} = sync_q;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scl_d_ff <= 1'b0;
			sda_d_ff <= 1'b0;
		end
		else
		begin
			scl_d_ff <= scl_q;
			sda_d_ff <= sda_q;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise   = scl_q & ~scl_d_ff;
	assign scl_fall   = ~scl_q & scl_d_ff;
	assign start_cond = scl_q & scl_d_ff & sda_d_ff & ~sda_q;
	assign stop_cond  = scl_q & scl_d_ff & ~sda_d_ff & sda_q;

	// ****************************************
	// Byte engine
	// ****************************************
	eeprom_pkg::target_state_t state_ff;
	eeprom_pkg::byte_kind_t    kind_ff;
	logic [3:0]        cnt_ff;
	logic [7:0]        sh_ff;
	logic [MEM_AW-1:0] addr_ff;
	logic              pend_ff;
	logic              busy_ff;
	logic [7:0]        mem_ff [2**MEM_AW];
	logic [7:0]        rx_byte;
	logic              byte_done;
	logic              sel_match;
	logic              tx_load;
	logic [7:0]        rd_byte;

	assign rx_byte   = {sh_ff[6:0], sda_q};
	assign byte_done = scl_rise & (state_ff == eeprom_pkg::ST_RX) & (cnt_ff == 4'h7);
	assign sel_match = rx_byte[eeprom_pkg::SEL_FIXED_POS] & (rx_byte[6:4] == straps_q);
	assign tx_load   = scl_fall
		& (((state_ff == eeprom_pkg::ST_ACK) & (kind_ff == eeprom_pkg::K_READ))
		| ((state_ff == eeprom_pkg::ST_TX) & (cnt_ff == 4'h0)));
	assign rd_byte   = mem_ff[addr_ff];

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_ff <= eeprom_pkg::ST_IDLE;
			kind_ff  <= eeprom_pkg::K_SEL;
			cnt_ff   <= 4'h0;
			sh_ff    <= eeprom_pkg::BYTE_RST;
			addr_ff  <= '0;
		end
		else if (busy_ff)
			state_ff <= eeprom_pkg::ST_IDLE;
		else if (start_cond)
		begin
			state_ff <= eeprom_pkg::ST_RX;
			kind_ff  <= eeprom_pkg::K_SEL;
			cnt_ff   <= 4'h0;
		end
		else if (stop_cond)
			state_ff <= eeprom_pkg::ST_IDLE;
		else if (tx_load)
		begin
			state_ff <= eeprom_pkg::ST_TX;
			sh_ff    <= {rd_byte[6:0], 1'b0};
			cnt_ff   <= 4'h1;
			addr_ff  <= addr_ff + 1'b1;
		end
		else
		begin
			case (state_ff)
				eeprom_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						sh_ff  <= rx_byte;
						cnt_ff <= cnt_ff + 4'h1;
					end
					if (byte_done)
					begin
						state_ff <= eeprom_pkg::ST_ACKW;
						case (kind_ff)
							eeprom_pkg::K_SEL:
							begin
								if (!sel_match)
									state_ff <= eeprom_pkg::ST_IDLE;
								addr_ff[MEM_AW-1 -: 3] <= rx_byte[3:1];
								kind_ff <= rx_byte[eeprom_pkg::SEL_RW_POS] ? eeprom_pkg::K_READ
									: eeprom_pkg::K_ADDR;
							end
							eeprom_pkg::K_ADDR:
							begin
								addr_ff[7:0] <= rx_byte;
								kind_ff      <= eeprom_pkg::K_DATA;
							end
							default:
							begin
								if (wp_q)
									state_ff <= eeprom_pkg::ST_IDLE;
								else
									addr_ff[PAGE_AW-1:0] <= addr_ff[PAGE_AW-1:0] + 1'b1;
							end
						endcase
					end
				end
				eeprom_pkg::ST_ACKW:
					if (scl_fall)
						state_ff <= eeprom_pkg::ST_ACK;
				eeprom_pkg::ST_ACK:
					if (scl_fall)
					begin
						state_ff <= eeprom_pkg::ST_RX;
						cnt_ff   <= 4'h0;
					end
				eeprom_pkg::ST_TX:
					if (scl_fall)
					begin
						if (cnt_ff == eeprom_pkg::CNT_LAST)
							state_ff <= eeprom_pkg::ST_RACK;
						else
						begin
							sh_ff  <= {sh_ff[6:0], 1'b0};
							cnt_ff <= cnt_ff + 4'h1;
						end
					end
				eeprom_pkg::ST_RACK:
					if (scl_rise)
					begin
						// Master ack asks for the next byte, nack ends the read
						state_ff <= sda_q ? eeprom_pkg::ST_IDLE : eeprom_pkg::ST_TX;
						cnt_ff   <= 4'h0;
					end
				default:
					state_ff <= eeprom_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Data line drive
	// ****************************************
	logic low_ff;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			low_ff <= 1'b0;
		else if (busy_ff || start_cond || stop_cond)
			low_ff <= 1'b0;
		else if (tx_load)
			low_ff <= ~rd_byte[7];
		else if (scl_fall)
		begin
			case (state_ff)
				eeprom_pkg::ST_ACKW: low_ff <= 1'b1;
				eeprom_pkg::ST_TX:   low_ff <= (cnt_ff != eeprom_pkg::CNT_LAST) & ~sh_ff[7];
				default:             low_ff <= 1'b0;
			endcase
		end
	end

	assign bus.tgt_sda_o  = 1'b0;
	assign bus.tgt_sda_oe = low_ff;

	// ****************************************
	// Page buffer and programming cycle
	// ****************************************
	logic [7:0]               buf_ff [2**PAGE_AW];
	logic [2**PAGE_AW-1:0]    valid_ff;
	logic [MEM_AW-PAGE_AW-1:0] page_ff;
	logic [31:0]              prog_cnt_ff;
	logic                     data_ok;
	logic                     prog_done;

	assign data_ok   = byte_done & (kind_ff == eeprom_pkg::K_DATA) & ~wp_q & ~busy_ff;
	assign prog_done = busy_ff & (prog_cnt_ff == 32'(PROG_CYCLES - 1));

	always_ff @(posedge clock_i)
	begin
		if (data_ok)
			buf_ff[addr_ff[PAGE_AW-1:0]] <= rx_byte;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			valid_ff <= '0;
			pend_ff  <= 1'b0;
		end
		else if (prog_done || (byte_done && kind_ff == eeprom_pkg::K_DATA && wp_q))
		begin
			valid_ff <= '0;
			pend_ff  <= 1'b0;
		end
		else if (stop_cond && !busy_ff)
			pend_ff <= 1'b0;
		else if (data_ok)
		begin
			valid_ff[addr_ff[PAGE_AW-1:0]] <= 1'b1;
			pend_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_ff     <= 1'b0;
			prog_cnt_ff <= 32'h0000_0000;
			page_ff     <= '0;
		end
		else if (stop_cond && !busy_ff && pend_ff && !wp_q)
		begin
			busy_ff     <= 1'b1;
			prog_cnt_ff <= 32'h0000_0000;
			page_ff     <= addr_ff[MEM_AW-1:PAGE_AW];
		end
		else if (busy_ff)
		begin
			busy_ff     <= ~prog_done;
			prog_cnt_ff <= prog_cnt_ff + 32'h0000_0001;
		end
	end

	// One buffered byte is committed per clock at the start of the cycle
	always_ff @(posedge clock_i)
	begin
		if (busy_ff && prog_cnt_ff < 32'(2**PAGE_AW) && valid_ff[prog_cnt_ff[PAGE_AW-1:0]])
			mem_ff[{page_ff, prog_cnt_ff[PAGE_AW-1:0]}] <= buf_ff[prog_cnt_ff[PAGE_AW-1:0]];
	end

	assign busy_o = busy_ff;
endmodule
`default_nettype wire

// ==== verilog/eeprom_pkg.sv ====
`default_nettype none
package eeprom_pkg;
	localparam int unsigned CLK_PERIOD_NS      = 25;
	localparam int unsigned SCL_PERIOD_NS      = 10000;
	localparam int unsigned SCL_QUARTER_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
	localparam int unsigned PROG_TIME_NS       = 2000000;
	localparam int unsigned PROG_CYCLES        = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned MEM_AW             = 11;
	localparam int unsigned PAGE_AW            = 4;
	localparam int unsigned SEL_FIXED_POS      = 7;
	localparam int unsigned SEL_RW_POS         = 0;
	localparam logic [3:0]  CMD_OFS            = 4'h0;
	localparam logic [3:0]  STAT_OFS           = 4'h4;
	localparam int unsigned CMD_START_POS      = 0;
	localparam int unsigned CMD_STOP_POS       = 1;
	localparam int unsigned CMD_WRITE_POS      = 2;
	localparam int unsigned CMD_READ_POS       = 3;
	localparam int unsigned CMD_NACK_POS       = 4;
	localparam int unsigned DATA_POS           = 8;
	localparam int unsigned STAT_BUSY_POS      = 0;
	localparam int unsigned STAT_ACK_POS       = 1;
	localparam logic [7:0]  BYTE_RST           = 8'h00;
	localparam logic [3:0]  CNT_LAST           = 4'h8;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACKW = 3'b010,
		ST_ACK  = 3'b011,
		ST_TX   = 3'b100,
		ST_RACK = 3'b101
	} target_state_t;

	typedef enum logic [1:0]
	{
		K_SEL  = 2'b00,
		K_ADDR = 2'b01,
		K_DATA = 2'b10,
		K_READ = 2'b11
	} byte_kind_t;

	typedef enum logic [1:0]
	{
		P_IDLE  = 2'b00,
		P_START = 2'b01,
		P_BIT   = 2'b10,
		P_STOP  = 2'b11
	} ctrl_phase_t;
endpackage
`default_nettype wire

// ==== verilog/twi_if.sv ====
`default_nettype none
interface twi_if;
	logic ctl_scl_o;
	logic ctl_scl_oe;
	logic ctl_sda_o;
	logic ctl_sda_oe;
	logic tgt_sda_o;
	logic tgt_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND bus: any enabled low driver pulls the line down
	assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
	assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));

	modport controller (output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe, input scl, sda);
	modport target (output tgt_sda_o, tgt_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// ==== verilog/line_sync.sv ====
`default_nettype none
module line_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	// Lines
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_ff <= '0;
			q_o     <= '0;
		end
		else
		begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/twi_controller.sv ====
`default_nettype none
module twi_controller #(
	parameter int unsigned QUARTER = eeprom_pkg::SCL_QUARTER_CYCLES
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Two-wire bus
	twi_if.controller        bus
);
	// ****************************************
	// Register slave
	// ****************************************
	eeprom_pkg::ctrl_phase_t phase_ff;
	logic        resp_ff;
	logic        hold;
	logic        launch;
	logic        busy;
	logic        acked_ff;
	logic [7:0]  rx_ff;

	assign busy   = (phase_ff != eeprom_pkg::P_IDLE);
	assign hold   = avs_write_i & (avs_address_i == eeprom_pkg::CMD_OFS) & busy;
	assign launch = resp_ff & avs_write_i & (avs_address_i == eeprom_pkg::CMD_OFS)
		& avs_byteenable_i[0];
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~resp_ff;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			resp_ff        <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end
		else
		begin
			// A command written while a byte is in flight waits here
			resp_ff <= (avs_read_i | avs_write_i) & ~resp_ff & ~hold;
			if (avs_read_i && !resp_ff)
			begin
				if (avs_address_i == eeprom_pkg::STAT_OFS)
					avs_readdata_o <= {16'h0000, rx_ff, 6'h00, acked_ff, busy};
				else
					avs_readdata_o <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Command latch and bit sequencer
	// ****************************************
	logic       do_stop_ff;
	logic       do_wr_ff;
	logic       do_rd_ff;
	logic       nack_ff;
	logic [7:0] tx_ff;
	logic [1:0] q_ff;
	logic [3:0] bit_ff;
	logic [31:0] div_ff;
	logic       tick;
	logic       scl_lvl_ff;
	logic       sda_lvl_ff;
	logic       sda_q;
	logic [31:0] cmd;

	assign cmd  = avs_writedata_i;
	assign tick = busy & (div_ff == 32'(QUARTER - 1));

	line_sync #(.W(1)) u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.d_i     (bus.sda),
		.q_o     (sda_q)
	);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			div_ff <= 32'h0000_0000;
		else if (launch || tick)
			div_ff <= 32'h0000_0000;
		else if (busy)
			div_ff <= div_ff + 32'h0000_0001;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			phase_ff   <= eeprom_pkg::P_IDLE;
			q_ff       <= 2'h0;
			bit_ff     <= 4'h0;
			do_stop_ff <= 1'b0;
			do_wr_ff   <= 1'b0;
			do_rd_ff   <= 1'b0;
			nack_ff    <= 1'b0;
			tx_ff      <= eeprom_pkg::BYTE_RST;
			rx_ff      <= eeprom_pkg::BYTE_RST;
			acked_ff   <= 1'b0;
			scl_lvl_ff <= 1'b1;
			sda_lvl_ff <= 1'b1;
		end
		else if (launch)
		begin
			do_stop_ff <= cmd[eeprom_pkg::CMD_STOP_POS];
			do_wr_ff   <= cmd[eeprom_pkg::CMD_WRITE_POS];
			do_rd_ff   <= cmd[eeprom_pkg::CMD_READ_POS] & ~cmd[eeprom_pkg::CMD_WRITE_POS];
			nack_ff    <= cmd[eeprom_pkg::CMD_NACK_POS];
			if (avs_byteenable_i[1])
				tx_ff <= cmd[eeprom_pkg::DATA_POS +: 8];
			q_ff   <= 2'h0;
			bit_ff <= 4'h0;
			if (cmd[eeprom_pkg::CMD_START_POS])
				phase_ff <= eeprom_pkg::P_START;
			else if (cmd[eeprom_pkg::CMD_WRITE_POS] | cmd[eeprom_pkg::CMD_READ_POS])
				phase_ff <= eeprom_pkg::P_BIT;
			else if (cmd[eeprom_pkg::CMD_STOP_POS])
				phase_ff <= eeprom_pkg::P_STOP;
		end
		else if (tick)
		begin
			q_ff <= q_ff + 2'h1;
			case (phase_ff)
				eeprom_pkg::P_START:
				begin
					case (q_ff)
						2'h0:    sda_lvl_ff <= 1'b1;
						2'h1:    scl_lvl_ff <= 1'b1;
						2'h2:    sda_lvl_ff <= 1'b0;
						default:
						begin
							scl_lvl_ff <= 1'b0;
							phase_ff   <= (do_wr_ff | do_rd_ff) ? eeprom_pkg::P_BIT
								: do_stop_ff ? eeprom_pkg::P_STOP : eeprom_pkg::P_IDLE;
						end
					endcase
				end
				eeprom_pkg::P_BIT:
				begin
					case (q_ff)
						// Data changes only while the clock is low
						2'h0:
							if (bit_ff == eeprom_pkg::CNT_LAST)
								sda_lvl_ff <= do_wr_ff | nack_ff;
							else
								sda_lvl_ff <= ~do_wr_ff | tx_ff[7];
						2'h1:    scl_lvl_ff <= 1'b1;
						2'h2:
							if (bit_ff == eeprom_pkg::CNT_LAST)
								acked_ff <= ~sda_q;
							else
								rx_ff <= {rx_ff[6:0], sda_q};
						default:
						begin
							scl_lvl_ff <= 1'b0;
							tx_ff      <= {tx_ff[6:0], 1'b0};
							bit_ff     <= bit_ff + 4'h1;
							if (bit_ff == eeprom_pkg::CNT_LAST)
								phase_ff <= do_stop_ff ? eeprom_pkg::P_STOP : eeprom_pkg::P_IDLE;
						end
					endcase
				end
				eeprom_pkg::P_STOP:
				begin
					case (q_ff)
						2'h0:    sda_lvl_ff <= 1'b0;
						2'h1:    scl_lvl_ff <= 1'b1;
						2'h2:    sda_lvl_ff <= 1'b1;
						default: phase_ff   <= eeprom_pkg::P_IDLE;
					endcase
				end
				default: phase_ff <= eeprom_pkg::P_IDLE;
			endcase
		end
	end

	assign bus.ctl_scl_o  = 1'b0;
	assign bus.ctl_scl_oe = ~scl_lvl_ff;
	assign bus.ctl_sda_o  = 1'b0;
	assign bus.ctl_sda_oe = ~sda_lvl_ff;
endmodule
`default_nettype wire

// ==== tb/twi_chk.sv ====
`default_nettype none
module twi_chk #(
	parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// Controller drives
	input  wire logic ctl_scl_o,
	input  wire logic ctl_scl_oe,
	input  wire logic ctl_sda_o,
	input  wire logic ctl_sda_oe,
	// Target drives and status
	input  wire logic tgt_sda_o,
	input  wire logic tgt_sda_oe,
	input  wire logic busy_o,
	// Resolved lines
	input  wire logic scl,
	input  wire logic sda
);
	logic [31:0] busy_cnt_ff;

	// Length of the programming pulse, counted in clocks
	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
			busy_cnt_ff <= 32'h0000_0000;
		else if (busy_o)
			busy_cnt_ff <= busy_cnt_ff + 32'h0000_0001;
		else
			busy_cnt_ff <= 32'h0000_0000;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// ****************************************
	// Line drive and programming checks
	// ****************************************
	tgt_open_drain_a: assert property (tgt_sda_oe |-> !tgt_sda_o)
		else $error("target drives data line high");
	ctl_open_drain_a: assert property ((ctl_sda_oe | ctl_scl_oe) |-> !(ctl_sda_o | ctl_scl_o))
		else $error("controller drives a line high");
	wire_low_a: assert property (tgt_sda_oe |-> !sda)
		else $error("data line high while target pulls");
	busy_deaf_a: assert property (busy_o |-> !tgt_sda_oe)
		else $error("target answers while programming");
	reset_quiet_a: assert property ($fell(rst_i)
		|-> !(tgt_sda_oe | busy_o | ctl_sda_oe | ctl_scl_oe))
		else $error("lines not released after reset");
	tgt_edge_a: assert property ($changed(tgt_sda_oe) |-> !scl)
		else $error("target changed data while clock high");
	prog_len_a: assert property ($fell(busy_o) |-> busy_cnt_ff >= PROG_CYCLES - 1
		&& busy_cnt_ff <= PROG_CYCLES + 1) else $error("programming length wrong");
	prog_idle_a: assert property ($rose(busy_o) |-> scl && !tgt_sda_oe)
		else $error("programming began outside a stop");

	cover property ($rose(busy_o));
	cover property ($rose(tgt_sda_oe));
	cover property (scl && $fell(sda));
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PROG = 400;
	localparam logic [4:0]  F_S  = 5'h01;
	localparam logic [4:0]  F_P  = 5'h02;
	localparam logic [4:0]  F_W  = 5'h04;
	localparam logic [4:0]  F_R  = 5'h08;
	localparam logic [4:0]  F_N  = 5'h10;
	localparam logic [7:0]  PAT [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
	logic        clock_i;
	logic        rst_i;
	logic [2:0]  straps;
	logic        wp;
	logic        busy;
	logic [3:0]  av_addr;
	logic        av_rd;
	logic        av_wr;
	logic [31:0] av_wdata;
	logic [31:0] av_rdata;
	logic        av_wait;
	logic [31:0] rdata;
	int          num_errors;
	int          tests_run;

	twi_if bus_if ();
	twi_controller #(.QUARTER(8)) twi_controller_i (.clock_i(clock_i), .rst_i(rst_i),
		.avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
		.avs_writedata_i(av_wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata),
		.avs_waitrequest_o(av_wait), .bus(bus_if.controller));
	eeprom_target #(.PROG_CYCLES(PROG)) eeprom_target_i (.clock_i(clock_i), .rst_i(rst_i),
		.chip_select_straps_i(straps), .write_protect_input_i(wp), .busy_o(busy),
		.bus(bus_if.target));
	twi_chk #(.PROG_CYCLES(PROG)) twi_chk_i (.clock_i(clock_i), .rst_i(rst_i),
		.ctl_scl_o(bus_if.ctl_scl_o), .ctl_scl_oe(bus_if.ctl_scl_oe),
		.ctl_sda_o(bus_if.ctl_sda_o), .ctl_sda_oe(bus_if.ctl_sda_oe),
		.tgt_sda_o(bus_if.tgt_sda_o), .tgt_sda_oe(bus_if.tgt_sda_oe), .busy_o(busy),
		.scl(bus_if.scl), .sda(bus_if.sda));

	always #12.5 clock_i = ~clock_i;

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic results();
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A used-up bound is a mismatch and ends the run
	task automatic over(input int n, input int lim);
		if (n == lim)
		begin
			chk(32'h0000_0000, 32'h0000_0001);
			results();
		end
	endtask

	// Called just after a rising edge; the request holds until the edge that sees
	// waitrequest low, read data is taken there, and one idle edge separates calls
	task automatic av_req(input logic rd, input logic [3:0] a, input logic [31:0] d);
		int n;
		av_addr <= a;
		av_rd <= rd;
		av_wr <= ~rd;
		av_wdata <= d;
		for (n = 0; n < 4000; n++)
		begin
			@(posedge clock_i);
			if (av_wait === 1'b0)
				break;
		end
		over(n, 4000);
		rdata = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic op(input logic [4:0] f, input logic [7:0] b);
		int n;
		av_req(1'b0, eeprom_pkg::CMD_OFS, {16'h0000, b, 3'h0, f});
		for (n = 0; n < 400; n++)
		begin
			av_req(1'b1, eeprom_pkg::STAT_OFS, 32'h0000_0000);
			if (rdata[eeprom_pkg::STAT_BUSY_POS] === 1'b0)
				break;
		end
		over(n, 400);
	endtask

	task automatic ack_is(input logic e);
		av_req(1'b1, eeprom_pkg::STAT_OFS, 32'h0000_0000);
		chk({31'h0, e}, {31'h0, rdata[eeprom_pkg::STAT_ACK_POS]});
	endtask

	task automatic byte_is(input logic [7:0] e);
		av_req(1'b1, eeprom_pkg::STAT_OFS, 32'h0000_0000);
		chk({24'h00_0000, e}, {24'h00_0000, rdata[15:8]});
	endtask

	task automatic wait_ready();
		int n;
		for (n = 0; n < 1000; n++)
		begin
			@(negedge clock_i);
			if (busy === 1'b0)
				break;
		end
		over(n, 1000);
		@(posedge clock_i);
	endtask

	function automatic logic [7:0] sel(input logic [2:0] s, input logic [2:0] hi, input logic rw);
		return {1'b1, s, hi, rw};
	endfunction

	task automatic rand_rd(input logic [10:0] a);
		op(F_S | F_W, sel(straps, a[10:8], 1'b0));
		ack_is(1'b1);
		op(F_W, a[7:0]);
		ack_is(1'b1);
		op(F_S | F_W, sel(straps, a[10:8], 1'b1));
		ack_is(1'b1);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		int i;
		clock_i = 1'b0;
		rst_i = 1'b1;
		straps = 3'h2;
		wp = 1'b0;
		av_addr = 4'h0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wdata = 32'h0000_0000;
		num_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		av_req(1'b1, eeprom_pkg::STAT_OFS, 32'h0000_0000);
		chk(32'h0000_0000, rdata);
		av_req(1'b1, 4'h8, 32'h0000_0000);
		chk(32'h0000_0000, rdata);
		// Four bytes from the page's second-last place must wrap inside the page
		op(F_S | F_W, sel(3'h2, 3'h3, 1'b0));
		ack_is(1'b1);
		op(F_W, 8'hFE);
		ack_is(1'b1);
		for (i = 0; i < 4; i++)
		begin
			op(i == 3 ? F_W | F_P : F_W, PAT[i]);
			ack_is(1'b1);
		end
		repeat (8) @(negedge clock_i);
		chk(32'h0000_0001, {31'h0, busy});
		@(posedge clock_i);
		op(F_S | F_W | F_P, sel(3'h2, 3'h3, 1'b0));
		ack_is(1'b0);
		wait_ready();
		rand_rd(11'h3FE);
		op(F_R, 8'h00);
		byte_is(PAT[0]);
		op(F_R | F_N | F_P, 8'h00);
		byte_is(PAT[1]);
		rand_rd(11'h3F0);
		op(F_R | F_N | F_P, 8'h00);
		byte_is(PAT[2]);
		op(F_S | F_W, sel(3'h2, 3'h3, 1'b1));
		ack_is(1'b1);
		op(F_R | F_N | F_P, 8'h00);
		byte_is(PAT[3]);
		// Protected write: select and address taken, data refused, memory kept
		wp <= 1'b1;
		op(F_S | F_W, sel(3'h2, 3'h3, 1'b0));
		ack_is(1'b1);
		op(F_W, 8'hFE);
		ack_is(1'b1);
		op(F_W | F_P, 8'h5A);
		ack_is(1'b0);
		repeat (20) @(negedge clock_i);
		chk(32'h0000_0000, {31'h0, busy});
		@(posedge clock_i);
		wp <= 1'b0;
		rand_rd(11'h3FE);
		op(F_R | F_N | F_P, 8'h00);
		byte_is(PAT[0]);
		// Straps change between accesses; a neighbouring pattern is refused
		for (i = 0; i < 8; i++)
		begin
			straps <= i[2:0];
			op(F_S | F_W | F_P, sel(i[2:0] ^ 3'h1, 3'h3, 1'b1));
			ack_is(1'b0);
			// Read back a written place only, so no unwritten cell reaches the line
			rand_rd(11'h3F1);
			op(F_R | F_N | F_P, 8'h00);
			byte_is(PAT[3]);
		end
		results();
	end
endmodule
`default_nettype wire
